// File: sim/coproc_load_mul_shift_instrs_tb_top.sv
// testbench for the load, multiply, shift and move instruction group
// assumes: lmx_core and lmx_ram_model compiled before this file
`default_nettype none
module coproc_load_mul_shift_instrs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, rst_n_in, op_valid_in, op_ready_out, bank_wr_in, mult_slow_in;
  logic        ram_rd_out, ram_ack_in, jump_out, instr_done_out;
  logic        flag_ovf_out, flag_sign_out, flag_carry_out, flag_zero_out;
  logic [7:0]  op_data_in, bank_data_in, ram_data_in;
  logic [3:0]  reg_sel_in, ram_dly;
  logic [23:0] ram_addr_out;
  logic [15:0] reg_data_out, pc_out, v;
  logic [23:0] aq[$];
  int          n_fail, checks_done, jumps, c;
  lmx_core lmx_core_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .op_data_in(op_data_in),
    .op_valid_in(op_valid_in), .op_ready_out(op_ready_out), .bank_wr_in(bank_wr_in),
    .bank_data_in(bank_data_in), .mult_slow_in(mult_slow_in), .ram_addr_out(ram_addr_out),
    .ram_rd_out(ram_rd_out), .ram_data_in(ram_data_in), .ram_ack_in(ram_ack_in),
    .reg_sel_in(reg_sel_in), .reg_data_out(reg_data_out), .pc_out(pc_out), .jump_out(jump_out),
    .instr_done_out(instr_done_out), .flag_ovf_out(flag_ovf_out), .flag_sign_out(flag_sign_out),
    .flag_carry_out(flag_carry_out), .flag_zero_out(flag_zero_out));
  lmx_ram_model lmx_ram_model_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ram_addr_in(ram_addr_out),
    .ram_rd_in(ram_rd_out), .delay_in(ram_dly), .ram_data_out(ram_data_in), .ram_ack_out(ram_ack_in));
  ////////////////////////////////////////////////////////////////////////
  // clock, address log and jump count
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (ram_ack_in === 1'b1) aq.push_back(ram_addr_out);
    if (jump_out === 1'b1) jumps++;
  end
  ////////////////////////////////////////////////////////////////////////
  // compare, report, stream and register access tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bytes go out back to back; valid is held until the last one is taken
  task automatic run(input logic [7:0] q[$], output int n);
    foreach (q[i]) begin
      op_data_in = q[i];
      op_valid_in = 1'b1;
      do @(posedge mclk_in); while (op_ready_out !== 1'b1);
      #1;
    end
    op_valid_in = 1'b0;
    for (n = 1; n < 60; n++) begin
      @(posedge mclk_in);
      if (ram_rd_out === 1'b1) chk(op_ready_out, 1'b0);
      if (instr_done_out === 1'b1) break;
    end
    #1;
    if (n == 60) chk(0, 1);
  endtask
  task automatic rd(input logic [3:0] sel, output logic [15:0] d);
    reg_sel_in = sel;
    repeat (2) @(posedge mclk_in);
    #1;
    d = reg_data_out;
  endtask
  task automatic ldw(input logic [3:0] n, input logic [15:0] val);
    logic [15:0] a;
    int k;
    a = 16'h0200 | {11'h000, n, 1'b0};
    lmx_ram_model_inst.mem[a[9:0]] = val[7:0];
    lmx_ram_model_inst.mem[a[9:0] + 10'h001] = val[15:8];
    run('{8'h3d, {4'hf, n}, a[7:0], a[15:8]}, k);
  endtask
  task automatic flags(input logic [3:0] exp, input logic [3:0] mask);
    chk({flag_ovf_out, flag_sign_out, flag_carry_out, flag_zero_out} & mask, exp & mask);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run length
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n_in = 1'b0; op_valid_in = 1'b0; op_data_in = 8'h00; bank_wr_in = 1'b0;
    bank_data_in = 8'h00; mult_slow_in = 1'b0; reg_sel_in = 4'h0; ram_dly = 4'h2;
    n_fail = 0; checks_done = 0; jumps = 0;
    repeat (20) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    flags(4'h0, 4'hf);
    bank_data_in = 8'h71;
    bank_wr_in = 1'b1;
    @(posedge mclk_in);
    #1 bank_wr_in = 1'b0;
    // short loads, prompt and slow ram, top of the reachable range
    for (int k = 0; k < 2; k++) begin
      logic [7:0] kk;
      kk = k ? 8'hff : 8'hd5;
      ram_dly = k ? 4'h3 : 4'h0;
      lmx_ram_model_inst.mem[{1'b0, kk, 1'b0}] = 8'h32 + k[7:0];
      lmx_ram_model_inst.mem[{1'b0, kk, 1'b1}] = 8'h92;
      aq.delete();
      run('{8'h3d, 8'ha3, kk}, c);
      chk(aq[0], {8'h71, 7'h00, kk, 1'b0});
      chk(aq[1], {8'h71, 7'h00, kk, 1'b1});
      rd(4'h3, v);
      chk(v, 16'h9232 + k);
    end
    $display("short load test done");
    // absolute load at an odd address takes the high byte from below
    lmx_ram_model_inst.mem[10'h3cd] = 8'h28;
    lmx_ram_model_inst.mem[10'h3cc] = 8'h96;
    run('{8'h3d, 8'hf9, 8'hcd, 8'h03}, c);
    rd(4'h9, v);
    chk(v, 16'h9628);
    $display("absolute load test done");
    // multiply at both speeds, source r9, destination r8
    ldw(4'h9, 16'hb556);
    ldw(4'h6, 16'hdaab);
    for (int s = 0; s < 2; s++) begin
      mult_slow_in = s[0];
      run('{8'hb9, 8'h18, 8'h3d, 8'h9f}, c);
      chk(c, s ? 9 : 5);
      flags(4'h2, 4'h7);
      rd(4'h8, v);
      chk(v, 16'h0ae3);
      rd(4'h4, v);
      chk(v, 16'h5c72);
    end
    $display("multiply test done");
    // default r0 operands for shift and low byte extract
    ldw(4'h0, 16'h8001);
    run('{8'h03}, c);
    rd(4'h0, v);
    chk(v, 16'h4000);
    flags(4'h2, 4'h6);
    run('{8'h9e}, c);
    rd(4'h0, v);
    chk(v, 16'h0000);
    flags(4'h1, 4'h5);
    ldw(4'h0, 16'h1280);
    run('{8'h9e}, c);
    rd(4'h0, v);
    chk(v, 16'h0080);
    flags(4'h4, 4'h5);
    $display("shift and extract test done");
    // high_byte_combine into r9, then an unprefixed shift must hit r0 again
    ldw(4'h7, 16'h05aa);
    ldw(4'h8, 16'hfc33);
    run('{8'h19, 8'h70}, c);
    flags(4'hf, 4'hf);
    rd(4'h9, v);
    chk(v, 16'h05fc);
    run('{8'h03}, c);
    rd(4'h9, v);
    chk(v, 16'h05fc);
    rd(4'h0, v);
    chk(v, 16'h0040);
    // register to register move r14 into r8
    ldw(4'he, 16'h4983);
    run('{8'h2e, 8'h18}, c);
    rd(4'h8, v);
    chk(v, 16'h4983);
    $display("high_byte_combine and move test done");
    // taken loop with its delay slot, then a falling-through loop
    ldw(4'hc, 16'h0002);
    ldw(4'hd, 16'h8014);
    jumps = 0;
    run('{8'h3c}, c);
    flags(4'h0, 4'h5);
    run('{8'h03}, c);
    repeat (3) @(posedge mclk_in);
    #1;
    chk(jumps, 1);
    chk(pc_out, 16'h8014);
    rd(4'h0, v);
    chk(v, 16'h0020);
    rd(4'hc, v);
    chk(v, 16'h0001);
    run('{8'h3c}, c);
    flags(4'h1, 4'h5);
    run('{8'h03}, c);
    repeat (3) @(posedge mclk_in);
    #1;
    chk(jumps, 1);
    $display("loop test done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// File: sim/lmx_ram_model.sv
// data ram stand-in: answers each byte read after a set number of wait cycles
// assumes: the design holds ram_rd_out and ram_addr_out until ram_ack_in
`default_nettype none
module lmx_ram_model (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [23:0] ram_addr_in,
  input  wire logic        ram_rd_in,
  input  wire logic [3:0]  delay_in,
  output logic      [7:0]  ram_data_out,
  output logic             ram_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:1023];
  logic [3:0] wait_r;
  ////////////////////////////////////////////////////////////////////////
  // wait, answer one byte, then invert the data every cycle so stale data is never held steady
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_r <= 4'h0;
      ram_ack_out <= 1'b0;
      ram_data_out <= 8'h00;
    end else if (ram_rd_in && !ram_ack_out && wait_r == delay_in) begin
      wait_r <= 4'h0;
      ram_ack_out <= 1'b1;
      ram_data_out <= mem[ram_addr_in[9:0]];
    end else begin
      wait_r <= (ram_rd_in && !ram_ack_out) ? wait_r + 4'h1 : 4'h0;
      ram_ack_out <= 1'b0;
      ram_data_out <= ~ram_data_out;
    end
  end
endmodule
`default_nettype wire

// File: verilog/lmx_core.sv
// load, multiply, shift and move instruction group of the coprocessor
// assumes: instruction bytes arrive on a valid/ready stream in pc order,
// data ram on the same clock, bank set through bank_wr_in
// Notes on behaviour
// - absolute word load stalls the stream until both ram bytes arrive.
// - short load address is the address byte doubled; low then next byte.
// - short load reaches only even addresses 0 to 510 in current bank.
// - short load is 3d, a0 plus register, then halved address byte.
// - multiply source by r6 signed; high half to dest, low half r4.
// - multiply copies r6 bit 15 into carry.
// - multiply takes 5 or 9 cycles depending on speed setting.
// - without prefixes source and destination are both r0.
// - low byte extract zeroes high byte; sign and zero from byte.
// - loop decrements r12; nonzero result branches to r13.
// - loop reaching zero sets zero flag and falls through.
// - taken loop executes the following instruction before branching.
// - logical shift moves source one place toward bit 0 into dest.
// - shift fills bit 15 with zero, old bit 0 to carry.
// - high_byte_combine puts r7 high byte high and r8 high byte low.
// - move copies any register into any register, full 16 bits.
`default_nettype none
module lmx_core (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  op_data_in,
  input  wire logic        op_valid_in,
  output logic             op_ready_out,
  input  wire logic        bank_wr_in,
  input  wire logic [7:0]  bank_data_in,
  input  wire logic        mult_slow_in,
  output logic      [23:0] ram_addr_out,
  output logic             ram_rd_out,
  input  wire logic [7:0]  ram_data_in,
  input  wire logic        ram_ack_in,
  input  wire logic [3:0]  reg_sel_in,
  output logic      [15:0] reg_data_out,
  output logic      [15:0] pc_out,
  output logic             jump_out,
  output logic             instr_done_out,
  output logic             flag_ovf_out,
  output logic             flag_sign_out,
  output logic             flag_carry_out,
  output logic             flag_zero_out
);
  lmx_pkg::lmx_state_t state_r, state_nxt;
  logic [15:0] regs_r [16];
  logic [7:0]  bank_r;
  logic        pfx_one_r, pfx_two_r, sel_r;
  logic [3:0]  src_r, dst_r, ld_r;
  logic [7:0]  addr_lo_r;
  logic [3:0]  wait_r;
  logic        pend_r;
  logic        ld_abs_r; // long-form load in progress
  logic [15:0] tgt_r;
  logic        take, done_nxt, wr_en, wr4_en, fetch_go, loop_take, mul_go;
  logic [3:0]  wr_idx;
  logic [15:0] wr_val, fetch_addr, src_v, cnt_dec;
  logic [3:0]  fl_we, fl_val;
  logic [31:0] prod;
  logic [15:0] fetch_word;
  logic        fetch_done;
  logic        jump_now;

  // zero test shared by the flag paths
  function automatic logic is_zero(input logic [15:0] v);
    return v == 16'h0000;
  endfunction

  assign src_v    = regs_r[src_r];
  assign prod     = $signed(src_v) * $signed(regs_r[lmx_pkg::R_MULT]);
  assign cnt_dec  = regs_r[lmx_pkg::R_CNT] - 16'h0001;
  assign jump_now = pend_r && done_nxt && (state_r == lmx_pkg::ST_OP ? !loop_take : 1'b1);

  // stream is open only while decoding or collecting operand bytes
  assign op_ready_out = (state_r == lmx_pkg::ST_OP) || (state_r == lmx_pkg::ST_IMM_LO)
                        || (state_r == lmx_pkg::ST_IMM_HI);

  //////////////////////////////////////////////////////////////////////////
  // decode and execute
  always_comb begin
    state_nxt  = state_r;
    take       = op_valid_in && op_ready_out;
    done_nxt   = 1'b0;
    wr_en      = 1'b0;
    wr_idx     = dst_r;
    wr_val     = 16'h0000;
    wr4_en     = 1'b0;
    fl_we      = 4'b0000;
    fl_val     = 4'b0000;
    fetch_go   = 1'b0;
    fetch_addr = 16'h0000;
    loop_take  = 1'b0;
    mul_go     = 1'b0;
    case (state_r)
      lmx_pkg::ST_OP: begin
        if (take) begin
          done_nxt = 1'b1;
          if (op_data_in == lmx_pkg::OP_PFX_ONE || op_data_in == lmx_pkg::OP_PFX_TWO) begin
            done_nxt = 1'b0;
          end else if (op_data_in[7:4] == lmx_pkg::HI_WITH) begin
            done_nxt = 1'b0;
          end else if (op_data_in[7:4] == lmx_pkg::HI_FROM && !sel_r) begin
            done_nxt = 1'b0;
          end else if (op_data_in[7:4] == lmx_pkg::HI_TO) begin
            if (sel_r) begin
              wr_en  = 1'b1;
              wr_idx = op_data_in[3:0];
              wr_val = src_v;
            end else begin
              done_nxt = 1'b0;
            end
          end else if (pfx_one_r && op_data_in == lmx_pkg::OP_MUL) begin
            done_nxt  = 1'b0;
            mul_go    = 1'b1;
            state_nxt = lmx_pkg::ST_MUL;
          end else if (pfx_one_r && op_data_in[7:4] == lmx_pkg::HI_LD_ABS) begin
            done_nxt  = 1'b0;
            state_nxt = lmx_pkg::ST_IMM_LO;
          end else if (pfx_one_r && op_data_in[7:4] == lmx_pkg::HI_LD_SHORT) begin
            done_nxt  = 1'b0;
            state_nxt = lmx_pkg::ST_IMM_HI;
          end else if (op_data_in == lmx_pkg::OP_LOWB) begin
            wr_en  = 1'b1;
            wr_val = {8'h00, src_v[7:0]};
            fl_we  = 4'b0101;
            fl_val = {1'b0, src_v[7], 1'b0, src_v[7:0] == 8'h00};
          end else if (op_data_in == lmx_pkg::OP_LOOP) begin
            wr_en     = 1'b1;
            wr_idx    = lmx_pkg::R_CNT;
            wr_val    = cnt_dec;
            fl_we     = 4'b0101;
            fl_val    = {1'b0, cnt_dec[15], 1'b0, is_zero(cnt_dec)};
            loop_take = !is_zero(cnt_dec);
          end else if (op_data_in == lmx_pkg::OP_SHR) begin
            wr_en  = 1'b1;
            wr_val = {1'b0, src_v[15:1]};
            fl_we  = 4'b0111;
            fl_val = {1'b0, 1'b0, src_v[0], is_zero({1'b0, src_v[15:1]})};
          end else if (op_data_in == lmx_pkg::OP_HIGH_BYTE_COMBINE) begin
            wr_en  = 1'b1;
            wr_val = {regs_r[lmx_pkg::R_MHI][15:8], regs_r[lmx_pkg::R_MLB][15:8]};
            fl_we  = 4'b1111;
            fl_val = {|{wr_val[15:14], wr_val[7:6]}, wr_val[15] | wr_val[7],
                      |{wr_val[15:13], wr_val[7:5]}, |{wr_val[15:12], wr_val[7:4]}};
          end
        end
      end
      lmx_pkg::ST_IMM_LO: begin
        if (take) begin
          state_nxt = lmx_pkg::ST_IMM_HI;
        end
      end
      lmx_pkg::ST_IMM_HI: begin
        if (take) begin
          fetch_go  = 1'b1;
          state_nxt = lmx_pkg::ST_RAM;
          if (!ld_abs_r) begin
            fetch_addr = {7'h00, op_data_in, 1'b0};
          end else begin
            fetch_addr = {op_data_in, addr_lo_r};
          end
        end
      end
      lmx_pkg::ST_RAM: begin
        if (fetch_done) begin
          wr_en     = 1'b1;
          wr_idx    = ld_r;
          wr_val    = fetch_word;
          done_nxt  = 1'b1;
          state_nxt = lmx_pkg::ST_OP;
        end
      end
      lmx_pkg::ST_MUL: begin
        if (wait_r == 4'h0) begin
          wr_en     = 1'b1;
          wr_val    = prod[31:16];
          wr4_en    = 1'b1;
          fl_we     = 4'b0111;
          fl_val    = {1'b0, prod[31], regs_r[lmx_pkg::R_MULT][15], is_zero(prod[31:16])};
          done_nxt  = 1'b1;
          state_nxt = lmx_pkg::ST_OP;
        end
      end
      default: state_nxt = lmx_pkg::ST_OP;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer state and multiply wait count
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r   <= lmx_pkg::ST_OP;
      wait_r    <= 4'h0;
      ld_r      <= lmx_pkg::R_DEF;
      addr_lo_r <= 8'h00;
      ld_abs_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (mul_go) begin
        wait_r <= mult_slow_in ? lmx_pkg::MUL_SLOW_WAIT : lmx_pkg::MUL_FAST_WAIT;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
      if (state_r == lmx_pkg::ST_OP && take) begin
        ld_r      <= op_data_in[3:0];
        ld_abs_r  <= op_data_in[7:4] == lmx_pkg::HI_LD_ABS;
        addr_lo_r <= 8'h00;
      end else if (state_r == lmx_pkg::ST_IMM_LO && take) begin
        addr_lo_r <= op_data_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prefix state: alternates and operand selection
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pfx_one_r <= 1'b0;
      pfx_two_r <= 1'b0;
      sel_r     <= 1'b0;
      src_r     <= lmx_pkg::R_DEF;
      dst_r     <= lmx_pkg::R_DEF;
    end else if (done_nxt) begin
      pfx_one_r <= 1'b0;
      pfx_two_r <= 1'b0;
      sel_r     <= 1'b0;
      src_r     <= lmx_pkg::R_DEF;
      dst_r     <= lmx_pkg::R_DEF;
    end else if (state_r == lmx_pkg::ST_OP && take) begin
      if (op_data_in == lmx_pkg::OP_PFX_ONE) begin
        pfx_one_r <= 1'b1;
      end else if (op_data_in == lmx_pkg::OP_PFX_TWO) begin
        pfx_two_r <= 1'b1;
      end else if (op_data_in[7:4] == lmx_pkg::HI_WITH) begin
        sel_r <= 1'b1;
        src_r <= op_data_in[3:0];
        dst_r <= op_data_in[3:0];
      end else if (op_data_in[7:4] == lmx_pkg::HI_FROM) begin
        src_r <= op_data_in[3:0];
      end else if (op_data_in[7:4] == lmx_pkg::HI_TO) begin
        dst_r <= op_data_in[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file, program counter in r15
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= lmx_pkg::REG_RST;
      end
    end else begin
      if (wr_en) begin
        regs_r[wr_idx] <= wr_val;
      end
      if (wr4_en) begin
        regs_r[lmx_pkg::R_MLO] <= prod[15:0];
      end
      if (jump_now) begin
        regs_r[lmx_pkg::R_PC] <= tgt_r;
      end else if (take && !(wr_en && wr_idx == lmx_pkg::R_PC)) begin
        regs_r[lmx_pkg::R_PC] <= regs_r[lmx_pkg::R_PC] + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // delayed branch: one instruction runs before the target
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r <= 1'b0;
      tgt_r  <= 16'h0000;
    end else if (loop_take) begin
      pend_r <= 1'b1;
      tgt_r  <= regs_r[lmx_pkg::R_TGT];
    end else if (jump_now) begin
      pend_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flags, bank, observation outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_ovf_out   <= 1'b0;
      flag_sign_out  <= 1'b0;
      flag_carry_out <= 1'b0;
      flag_zero_out  <= 1'b0;
      bank_r         <= lmx_pkg::BANK_RST;
      reg_data_out   <= 16'h0000;
      jump_out       <= 1'b0;
      instr_done_out <= 1'b0;
    end else begin
      if (fl_we[lmx_pkg::FL_OV]) flag_ovf_out <= fl_val[lmx_pkg::FL_OV];
      if (fl_we[lmx_pkg::FL_S]) flag_sign_out <= fl_val[lmx_pkg::FL_S];
      if (fl_we[lmx_pkg::FL_CY]) flag_carry_out <= fl_val[lmx_pkg::FL_CY];
      if (fl_we[lmx_pkg::FL_Z]) flag_zero_out <= fl_val[lmx_pkg::FL_Z];
      if (bank_wr_in) bank_r <= bank_data_in;
      reg_data_out   <= regs_r[reg_sel_in];
      jump_out       <= jump_now;
      instr_done_out <= done_nxt;
    end
  end

  assign pc_out = regs_r[lmx_pkg::R_PC];

  lmx_ramfetch u_fetch (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .start_in     (fetch_go),
    .addr_in      (fetch_addr),
    .bank_in      (bank_r),
    .ram_addr_out (ram_addr_out),
    .ram_rd_out   (ram_rd_out),
    .ram_data_in  (ram_data_in),
    .ram_ack_in   (ram_ack_in),
    .word_out     (fetch_word),
    .done_out     (fetch_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_mul_fast;
    mul_go && !mult_slow_in;
  endsequence
  sequence s_mul_slow;
    mul_go && mult_slow_in;
  endsequence
  sequence s_loop_taken;
    loop_take ##1 instr_done_out;
  endsequence

  a_mul_fast_len: assert property (s_mul_fast |-> !instr_done_out [*5] ##1 instr_done_out)
    else $error("fast multiply length wrong");
  a_mul_slow_len: assert property (s_mul_slow |-> ##9 instr_done_out)
    else $error("slow multiply length wrong");
  a_mul_carry: assert property (state_r == lmx_pkg::ST_MUL && wait_r == 4'h0
    |=> flag_carry_out == $past(regs_r[lmx_pkg::R_MULT][15]))
    else $error("multiply carry not from r6 bit 15");
  a_ram_stall: assert property (ram_rd_out |-> !op_ready_out)
    else $error("stream open during ram wait");
  a_short_addr: assert property (state_r == lmx_pkg::ST_IMM_HI && take && !ld_abs_r
    |=> ram_addr_out[15:0] == {7'h00, $past(op_data_in), 1'b0} && ram_rd_out)
    else $error("short load address not doubled");
  a_prefix_clear: assert property (instr_done_out |-> !pfx_one_r && !pfx_two_r && !sel_r
    && src_r == lmx_pkg::R_DEF)
    else $error("prefix state left after instruction");
  a_loop_exit: assert property (loop_take == 1'b0 && state_r == lmx_pkg::ST_OP && take
    && op_data_in == lmx_pkg::OP_LOOP |=> flag_zero_out)
    else $error("loop exit without zero flag");
  a_delay_slot: assert property (s_loop_taken |-> !jump_out)
    else $error("branch taken before delay slot");
  a_jump_target: assert property (jump_out |-> pc_out == $past(tgt_r))
    else $error("branch target not r13");
endmodule
`default_nettype wire

// File: verilog/lmx_pkg.sv
// package for the coprocessor load, multiply and shift instruction group
// assumes: single 250 MHz clock, byte-wide instruction stream, byte-wide data ram
`default_nettype none
package lmx_pkg;
  // opcode bytes
  localparam logic [7:0] OP_PFX_ONE = 8'h3d;
  localparam logic [7:0] OP_PFX_TWO = 8'h3e;
  localparam logic [7:0] OP_MUL     = 8'h9f;
  localparam logic [7:0] OP_LOWB    = 8'h9e;
  localparam logic [7:0] OP_LOOP    = 8'h3c;
  localparam logic [7:0] OP_SHR     = 8'h03;
  localparam logic [7:0] OP_HIGH_BYTE_COMBINE   = 8'h70;
  // opcode high nibbles carrying a register number
  localparam logic [3:0] HI_TO       = 4'h1;
  localparam logic [3:0] HI_WITH     = 4'h2;
  localparam logic [3:0] HI_FROM     = 4'hb;
  localparam logic [3:0] HI_LD_SHORT = 4'ha;
  localparam logic [3:0] HI_LD_ABS   = 4'hf;
  // fixed register numbers
  localparam logic [3:0] R_DEF    = 4'h0;
  localparam logic [3:0] R_MLO    = 4'h4;
  localparam logic [3:0] R_MULT   = 4'h6;
  localparam logic [3:0] R_MHI    = 4'h7;
  localparam logic [3:0] R_MLB    = 4'h8;
  localparam logic [3:0] R_CNT    = 4'hc;
  localparam logic [3:0] R_TGT    = 4'hd;
  localparam logic [3:0] R_PC     = 4'hf;
  // reset values
  localparam logic [15:0] REG_RST  = 16'h0000;
  localparam logic [7:0]  BANK_RST = 8'h00;
  // multiply length in cycles, opcode cycle included
  localparam int MUL_FAST_CYC = 5;
  localparam int MUL_SLOW_CYC = 9;
  localparam logic [3:0] MUL_FAST_WAIT = 4'(MUL_FAST_CYC - 2);
  localparam logic [3:0] MUL_SLOW_WAIT = 4'(MUL_SLOW_CYC - 2);
  // flag vector positions
  localparam int FL_OV = 3;
  localparam int FL_S  = 2;
  localparam int FL_CY = 1;
  localparam int FL_Z  = 0;
  typedef enum logic [4:0] {
    ST_OP     = 5'b00001,
    ST_IMM_LO = 5'b00010,
    ST_IMM_HI = 5'b00100,
    ST_RAM    = 5'b01000,
    ST_MUL    = 5'b10000
  } lmx_state_t;
  typedef enum logic [2:0] {
    FT_IDLE = 3'b001,
    FT_LOW  = 3'b010,
    FT_HIGH = 3'b100
  } lmx_fetch_t;
endpackage
`default_nettype wire

// File: verilog/lmx_ramfetch.sv
// two-byte data ram word fetch with wait on each byte
// assumes: ram answers on the same clock, ram_ack_in marks valid data
`default_nettype none
module lmx_ramfetch (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  bank_in,
  output logic      [23:0] ram_addr_out,
  output logic             ram_rd_out,
  input  wire logic [7:0]  ram_data_in,
  input  wire logic        ram_ack_in,
  output logic      [15:0] word_out,
  output logic             done_out
);
  lmx_pkg::lmx_fetch_t state_r;
  logic [7:0]          lo_r;

  //////////////////////////////////////////////////////////////////////////
  // byte sequencer: low byte, then its partner
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r      <= lmx_pkg::FT_IDLE;
      ram_addr_out <= 24'h000000;
      lo_r         <= 8'h00;
      word_out     <= 16'h0000;
      done_out     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        lmx_pkg::FT_IDLE: begin
          if (start_in) begin
            ram_addr_out <= {bank_in, addr_in};
            state_r      <= lmx_pkg::FT_LOW;
          end
        end
        lmx_pkg::FT_LOW: begin
          if (ram_ack_in) begin
            lo_r              <= ram_data_in;
            // partner byte: +1 when even, -1 when odd
            ram_addr_out[0]   <= ~ram_addr_out[0];
            state_r           <= lmx_pkg::FT_HIGH;
          end
        end
        lmx_pkg::FT_HIGH: begin
          if (ram_ack_in) begin
            word_out <= {ram_data_in, lo_r};
            done_out <= 1'b1;
            state_r  <= lmx_pkg::FT_IDLE;
          end
        end
        default: state_r <= lmx_pkg::FT_IDLE;
      endcase
    end
  end

  // read strobe held while a byte is outstanding
  assign ram_rd_out = (state_r == lmx_pkg::FT_LOW) || (state_r == lmx_pkg::FT_HIGH);
endmodule
`default_nettype wire
